/* core/rts_top.sv */
// Reset time-out sequencer with power control status and reset-initialised registers
//
// The Wishbone interface to the registers was left to the implementer.
`timescale 1ns/1ps
module rts_top #(
  parameter int DELAY_TICKS = rts_pkg::RTS_DELAY_TICKS,        // Power-up delay in timebase ticks
  parameter int TICK_CYCLES = rts_pkg::RTS_TICK_CYCLES,        // Clock cycles per timebase tick
  parameter int SETTLE_EDGES = rts_pkg::RTS_SETTLE_EDGES       // Oscillator edges to settle
) (
  input wire logic MCLK_I,                                     // System clock, 20 MHz
  input wire logic RST_I,                                      // Synchronous reset, active high
  input wire logic [11:0] ADR_I,                               // Wishbone byte address
  input wire logic [31:0] DAT_I,                               // Wishbone write data
  output logic [31:0] DAT_O,                                   // Wishbone read data
  input wire logic WE_I,                                       // Wishbone write enable
  input wire logic [3:0] SEL_I,                                // Wishbone byte select
  input wire logic STB_I,                                      // Wishbone strobe
  input wire logic CYC_I,                                      // Wishbone cycle
  output logic ACK_O,                                          // Wishbone acknowledge
  input wire logic POWER_ON_RESET_I,                           // Power-on reset pulse, high
  input wire logic BROWNOUT_I,                                 // Brown-out detector, high
  input wire logic EXTERNAL_RESET_N_I,                         // External reset pin, low
  input wire logic WATCHDOG_TIMER_RESET_I,                     // Watchdog reset pulse
  input wire logic WAKE_I,                                     // Wake from sleep pulse
  input wire logic OSC_I,                                      // Oscillator input, sampled
  input wire rts_pkg::rts_osc_mode_e OSC_MODE_I,               // Oscillator mode select
  input wire logic POWER_UP_DELAY_DISABLE_N_I,                 // 1 disables power-up delay
  input wire logic [1:0] BROWNOUT_DETECT_CFG_I,                // 00 disables brown-out
  output logic CORE_RESET_O,                                   // Core held in reset
  output logic EXEC_HOLD_O,                                    // Program counter suspended
  output logic [7:0] PORT_A_DIRECTION_O,                       // Port A direction register
  output logic [7:0] OPTION_O,                                 // Option register
  output logic [5:0] OSC_TRIM_REGISTER_O,                      // Oscillator trim register
  output logic [15:0] TIMER3_O,                                // Timer-3 counter bytes
  output logic [1:0] POWER_CONTROL_STATUS_O                    // Power control status bits
);
  import rts_pkg::*;

  // Crystal mode decode, used by sequencer and status
  function automatic logic is_crystal(input rts_osc_mode_e m);
    is_crystal = (m == RTS_LOW_GAIN_CRYSTAL) || (m == RTS_MEDIUM_GAIN_CRYSTAL) ||
                 (m == RTS_HIGH_GAIN_CRYSTAL);
  endfunction

  // Brown-out counts only when detector is enabled
  // A disabled detector is ignored entirely, so its flag stays put
  logic brownout_hit;
  logic por_or_brownout;
  logic pin_or_wd;
  logic delay_on;
  logic crystal;
  assign brownout_hit = BROWNOUT_I && (BROWNOUT_DETECT_CFG_I != RTS_BROWNOUT_DISABLED);
  assign por_or_brownout = POWER_ON_RESET_I || brownout_hit;
  // Pin and watchdog resets do not restart the time-outs
  assign pin_or_wd = !EXTERNAL_RESET_N_I || WATCHDOG_TIMER_RESET_I;
  assign delay_on = !POWER_UP_DELAY_DISABLE_N_I;
  assign crystal = is_crystal(OSC_MODE_I);

  // Free-running timebase, independent of oscillator mode
  logic [11:0] tb_cnt_q;
  logic [11:0] tb_cnt_d;
  logic tick;
  always_comb begin
    tick = (tb_cnt_q == 12'(TICK_CYCLES - 1));
    tb_cnt_d = tick ? 12'h000 : tb_cnt_q + 12'h001;
  end
  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      tb_cnt_q <= 12'h000;
    end else begin
      tb_cnt_q <= tb_cnt_d;
    end
  end

  // Sequencer state and one counter shared by delay and settle
  rts_state_e state_q;
  rts_state_e state_d;
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  logic osc_q;
  logic osc_rise;
  assign osc_rise = OSC_I && !osc_q;
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    if (por_or_brownout) begin
      state_d = RTS_ST_HOLD;
      cnt_d = 16'h0000;
    end else begin
      case (state_q)
        RTS_ST_HOLD: begin
          cnt_d = 16'h0000;
          if (delay_on) begin
            state_d = RTS_ST_DELAY;
          end else if (crystal) begin
            state_d = RTS_ST_SETTLE;
          end else begin
            state_d = RTS_ST_RUN;
          end
        end
        RTS_ST_DELAY: begin
          if (tick) begin
            if (cnt_q == 16'(DELAY_TICKS - 1)) begin
              cnt_d = 16'h0000;
              state_d = crystal ? RTS_ST_SETTLE : RTS_ST_RUN;
            end else begin
              cnt_d = cnt_q + 16'h0001;
            end
          end
        end
        RTS_ST_SETTLE: begin
          if (osc_rise) begin
            if (cnt_q == 16'(SETTLE_EDGES - 1)) begin
              cnt_d = 16'h0000;
              state_d = RTS_ST_RUN;
            end else begin
              cnt_d = cnt_q + 16'h0001;
            end
          end
        end
        RTS_ST_RUN: begin
          if (WAKE_I && crystal) begin
            state_d = RTS_ST_SETTLE;
            cnt_d = 16'h0000;
          end
        end
        default: begin
          state_d = RTS_ST_HOLD;
          cnt_d = 16'h0000;
        end
      endcase
    end
  end
  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      state_q <= RTS_ST_HOLD;
      cnt_q <= 16'h0000;
      osc_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      osc_q <= OSC_I;
    end
  end

  // Wake settle is distinguished from power-up by a flag
  logic waking_q;
  logic waking_d;
  always_comb begin
    waking_d = waking_q;
    if (por_or_brownout) begin
      waking_d = 1'b0;
    end else if (state_q == RTS_ST_RUN && WAKE_I && crystal) begin
      waking_d = 1'b1;
    end else if (state_q == RTS_ST_RUN) begin
      waking_d = 1'b0;
    end
  end

  // Reset and hold outputs
  // Pin and watchdog only gate final release
  assign CORE_RESET_O = por_or_brownout || pin_or_wd || ((state_q != RTS_ST_RUN) && !waking_q);
  assign EXEC_HOLD_O = CORE_RESET_O || (state_q != RTS_ST_RUN);

  // Software-visible registers
  logic [7:0] dir_q;
  logic [7:0] dir_d;
  logic [7:0] opt_q;
  logic [7:0] opt_d;
  logic [5:0] trim_q;
  logic [5:0] trim_d;
  logic [15:0] tmr3_q;
  logic [15:0] tmr3_d;
  logic [1:0] pwr_q;
  logic [1:0] pwr_d;
  logic ack_q;
  logic ack_d;
  logic [31:0] rdat_q;
  logic [31:0] rdat_d;
  logic wr;
  logic [9:0] idx;
  assign idx = ADR_I[11:2];
  // Write lands at the edge where the master sees ack high
  // Address and data still stand then, so no capture register is needed
  assign wr = CYC_I && STB_I && WE_I && ack_q && SEL_I[0];

  always_comb begin
    dir_d = dir_q;
    opt_d = opt_q;
    trim_d = trim_q;
    tmr3_d = tmr3_q;
    pwr_d = pwr_q;
    // Software writes, low byte lane
    if (wr) begin
      case (idx)
        RTS_PORT_A_DIR_IDX: dir_d = DAT_I[7:0];
        RTS_OPTION_IDX: opt_d = DAT_I[7:0];
        RTS_OSC_TRIM_IDX: trim_d = DAT_I[5:0];
        RTS_TMR3_LO_IDX: tmr3_d[7:0] = DAT_I[7:0];
        RTS_TMR3_HI_IDX: tmr3_d[15:8] = DAT_I[7:0];
        RTS_PWR_CTRL_IDX: pwr_d = DAT_I[1:0];
        default: begin
        end
      endcase
    end
    if (por_or_brownout || pin_or_wd) begin
      dir_d = RTS_ALL_ONES;
      opt_d = RTS_ALL_ONES;
    end
    if (por_or_brownout) begin
      trim_d = RTS_OSC_TRIM_INIT;
      tmr3_d = tmr3_q;
    end
    // Hardware clears below win over a same-cycle software write
    // Power-on clears bit 1
    if (POWER_ON_RESET_I) begin
      pwr_d[RTS_POR_FLAG_BIT] = 1'b0;
    end
    if (brownout_hit) begin
      pwr_d[RTS_BROWNOUT_FLAG_BIT] = 1'b0;
    end
  end

  // Wishbone answer, one wait state, unmapped reads zero
  always_comb begin
    ack_d = CYC_I && STB_I && !ack_q;
    rdat_d = 32'h0000_0000;
    case (idx)
      RTS_PORT_A_DIR_IDX: rdat_d[7:0] = dir_q;
      RTS_OPTION_IDX: rdat_d[7:0] = opt_q;
      RTS_OSC_TRIM_IDX: rdat_d[5:0] = trim_q;
      RTS_TMR3_LO_IDX: rdat_d[7:0] = tmr3_q[7:0];
      RTS_TMR3_HI_IDX: rdat_d[7:0] = tmr3_q[15:8];
      RTS_PWR_CTRL_IDX: rdat_d[1:0] = pwr_q;
      RTS_MODE_STAT_IDX: rdat_d[3:0] = {waking_q, state_q};
      default: rdat_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      dir_q <= RTS_ALL_ONES;
      opt_q <= RTS_ALL_ONES;
      trim_q <= RTS_OSC_TRIM_INIT;
      tmr3_q <= {RTS_TMR3_RST, RTS_TMR3_RST};
      pwr_q <= RTS_PWR_CTRL_RST;
      waking_q <= 1'b0;
      ack_q <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else begin
      dir_q <= dir_d;
      opt_q <= opt_d;
      trim_q <= trim_d;
      tmr3_q <= tmr3_d;
      pwr_q <= pwr_d;
      waking_q <= waking_d;
      ack_q <= ack_d;
      rdat_q <= rdat_d;
    end
  end

  // Register-sourced outputs
  assign ACK_O = ack_q;
  assign DAT_O = rdat_q;
  assign PORT_A_DIRECTION_O = dir_q;
  assign OPTION_O = opt_q;
  assign OSC_TRIM_REGISTER_O = trim_q;
  assign TIMER3_O = tmr3_q;
  assign POWER_CONTROL_STATUS_O = pwr_q;

endmodule

/* core/rts_pkg.sv */
// Constants and types shared by the reset time-out sequencer
package rts_pkg;

  // Register indices; byte address is four times the index
  localparam logic [9:0] RTS_OPTION_IDX = 10'h081;
  localparam logic [9:0] RTS_PORT_A_DIR_IDX = 10'h085;
  localparam logic [9:0] RTS_PWR_CTRL_IDX = 10'h08E;
  localparam logic [9:0] RTS_OSC_TRIM_IDX = 10'h091;
  localparam logic [9:0] RTS_TMR3_LO_IDX = 10'h09A;
  localparam logic [9:0] RTS_TMR3_HI_IDX = 10'h09B;
  localparam logic [9:0] RTS_MODE_STAT_IDX = 10'h0C0;

  // Field positions of power_control_status
  localparam int RTS_BROWNOUT_FLAG_BIT = 0;
  localparam int RTS_POR_FLAG_BIT = 1;

  // Reset and initial values
  localparam logic [7:0] RTS_ALL_ONES = 8'hFF;
  localparam logic [5:0] RTS_OSC_TRIM_INIT = 6'h00;
  localparam logic [1:0] RTS_PWR_CTRL_RST = 2'h0;
  localparam logic [7:0] RTS_TMR3_RST = 8'h00;
  localparam logic [1:0] RTS_BROWNOUT_DISABLED = 2'h0;

  // Timing: clock rate, timebase tick, delay length, settle count
  localparam int RTS_CLK_PERIOD_NS = 50;
  localparam int RTS_TICK_PERIOD_NS = 1000;
  localparam int RTS_TICK_CYCLES = (RTS_TICK_PERIOD_NS + RTS_CLK_PERIOD_NS - 1) / RTS_CLK_PERIOD_NS;
  localparam int RTS_DELAY_TICKS = 64;
  localparam int RTS_SETTLE_EDGES = 1024;

  // Oscillator mode select codes
  typedef enum logic [2:0] {
    RTS_LOW_GAIN_CRYSTAL = 3'h0,
    RTS_MEDIUM_GAIN_CRYSTAL = 3'h1,
    RTS_HIGH_GAIN_CRYSTAL = 3'h2,
    RTS_EXTERNAL_CLOCK_INPUT = 3'h3,
    RTS_RESISTOR_CAPACITOR_OSC = 3'h4,
    RTS_INTERNAL_OSC = 3'h5
  } rts_osc_mode_e;

  // Sequencer states
  typedef enum logic [2:0] {
    RTS_ST_HOLD,
    RTS_ST_DELAY,
    RTS_ST_SETTLE,
    RTS_ST_RUN
  } rts_state_e;

endpackage

/* bench/rts_top_sva.sv */
// Port assertions for the reset time-out sequencer
`timescale 1ns/1ps
module rts_sva (
  input wire logic MCLK_I,
  input wire logic RST_I,
  input wire logic WE_I,
  input wire logic STB_I,
  input wire logic CYC_I,
  input wire logic ACK_O,
  input wire logic POWER_ON_RESET_I,
  input wire logic BROWNOUT_I,
  input wire logic EXTERNAL_RESET_N_I,
  input wire logic WATCHDOG_TIMER_RESET_I,
  input wire logic [1:0] BROWNOUT_DETECT_CFG_I,
  input wire logic CORE_RESET_O,
  input wire logic EXEC_HOLD_O,
  input wire logic [7:0] PORT_A_DIRECTION_O,
  input wire logic [7:0] OPTION_O,
  input wire logic [5:0] OSC_TRIM_REGISTER_O,
  input wire logic [15:0] TIMER3_O,
  input wire logic [1:0] POWER_CONTROL_STATUS_O
);
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (RST_I);
  // Enabled brown-out and bus write request
  wire brn_on = BROWNOUT_I && (BROWNOUT_DETECT_CFG_I != 2'h0);
  wire wr_req = CYC_I && STB_I && WE_I;
  AST_POR_HOLDS: assert property (POWER_ON_RESET_I |-> CORE_RESET_O ##1 CORE_RESET_O)
    else $error("core released during power-on pulse");
  AST_PIN_HOLDS: assert property (!EXTERNAL_RESET_N_I |-> CORE_RESET_O && EXEC_HOLD_O)
    else $error("core runs while pin low");
  AST_POR_FLAG: assert property (POWER_ON_RESET_I |=> !POWER_CONTROL_STATUS_O[1])
    else $error("power-on flag not cleared");
  AST_BRN_FLAG: assert property (brn_on |=> !POWER_CONTROL_STATUS_O[0])
    else $error("brown-out flag not cleared");
  AST_FLAGS_KEEP: assert property (!POWER_ON_RESET_I && !brn_on && !wr_req |=> $stable(POWER_CONTROL_STATUS_O))
    else $error("status flags changed without cause");
  AST_DIR_ONES: assert property (POWER_ON_RESET_I || brn_on || !EXTERNAL_RESET_N_I || WATCHDOG_TIMER_RESET_I
    |=> PORT_A_DIRECTION_O == 8'hFF && OPTION_O == 8'hFF)
    else $error("direction or option not all ones");
  AST_TRIM_CLR: assert property (POWER_ON_RESET_I || brn_on |=> OSC_TRIM_REGISTER_O == 6'h00)
    else $error("trim not cleared");
  AST_TMR3_KEEP: assert property (!wr_req |=> $stable(TIMER3_O))
    else $error("timer-3 changed without write");
  AST_BUS_ACK: assert property (CYC_I && STB_I && !ACK_O |=> ACK_O ##1 !ACK_O)
    else $error("acknowledge not one cycle after request");
  // Main scenarios reached
  cover property (POWER_ON_RESET_I ##1 !POWER_ON_RESET_I);
  cover property ($fell(CORE_RESET_O));
  cover property (brn_on);
  cover property (EXEC_HOLD_O && !CORE_RESET_O);
endmodule
bind rts_top rts_sva u_sva (.*);

/* bench/tb_top.sv */
// Self-checking bench for the reset time-out sequencer
`timescale 1ns/1ps
module tb_top;
  import rts_pkg::*;
  localparam int D = 4;
  localparam int T = 2;
  localparam int S = 8;
  logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, osc = 1'b0, dis_n = 1'b0;
  logic [3:0] sel = 4'hF;
  logic [11:0] adr = 12'h000;
  logic [31:0] dat = 32'h0, dat_o;
  logic [4:0] src = 5'h01;
  logic [1:0] bcfg = 2'h1, pwr;
  rts_osc_mode_e mode = RTS_MEDIUM_GAIN_CRYSTAL;
  logic ack, core_rst, hold;
  logic [7:0] dir, opt;
  logic [5:0] trim;
  logic [15:0] tmr3;
  int errors = 0, checked = 0, tmo = 0, n, lo, hi;
  rts_top #(.DELAY_TICKS(D), .TICK_CYCLES(T), .SETTLE_EDGES(S)) dut (
    .MCLK_I(clk), .RST_I(rst), .ADR_I(adr), .DAT_I(dat), .DAT_O(dat_o), .WE_I(we), .SEL_I(sel),
    .STB_I(stb), .CYC_I(cyc), .ACK_O(ack), .POWER_ON_RESET_I(src[0]), .BROWNOUT_I(src[1]),
    .EXTERNAL_RESET_N_I(~src[2]), .WATCHDOG_TIMER_RESET_I(src[3]), .WAKE_I(src[4]), .OSC_I(osc),
    .OSC_MODE_I(mode), .POWER_UP_DELAY_DISABLE_N_I(dis_n), .BROWNOUT_DETECT_CFG_I(bcfg),
    .CORE_RESET_O(core_rst), .EXEC_HOLD_O(hold), .PORT_A_DIRECTION_O(dir), .OPTION_O(opt),
    .OSC_TRIM_REGISTER_O(trim), .TIMER3_O(tmr3), .POWER_CONTROL_STATUS_O(pwr));
  // Clock, free-running oscillator, hang guard
  always #25 clk = ~clk;
  always @(posedge clk) osc <= ~osc;
  always @(posedge clk) begin
    tmo++;
    if (tmo == 5000) begin
      errors++;
      tally_and_finish();
    end
  end
  task automatic cy(input int k);
    repeat (k) @(posedge clk);
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Classic single bus cycle, held until acknowledge
  task automatic bus(input logic [11:0] a, input logic w, input logic [7:0] d, output logic [31:0] q);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= {24'h0, d};
    do @(posedge clk); while (ack !== 1'b1);
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(a, 1'b1, d, q);
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    logic [31:0] q;
    bus(a, 1'b0, 8'h00, q);
    chk($sformatf("reg %h", a), {24'h0, e}, q);
  endtask
  // Raise reset sources for len cycles
  task automatic kick(input logic [4:0] m, input int len);
    @(posedge clk);
    src <= m;
    cy(len);
    src <= 5'h00;
  endtask
  task automatic meas(input logic w);
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while ((w ? hold : core_rst) === 1'b1 && n < 99);
  endtask
  task automatic tally_and_finish();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    cy(5);
    rst <= 1'b0;
    // Release time for every mode, delay on and off
    for (int i = 0; i < 12; i++) begin
      mode <= rts_osc_mode_e'(i[3:1]);
      dis_n <= i[0];
      lo = 1 + (i[0] ? 0 : (D - 1) * T) + (i < 6 ? 2 * S - 2 : 0);
      hi = 2 + (i[0] ? 0 : D * T + 2) + (i < 6 ? 2 * S + 2 : 0);
      kick(5'h01, 3);
      meas(1'b0);
      chk($sformatf("cycles %0d", n), 32'h1, {31'h0, n >= lo && n <= hi});
    end
    mode <= RTS_MEDIUM_GAIN_CRYSTAL;
    kick(5'h01, 3);
    meas(1'b0);
    rd(12'h238, 8'h00);
    rd(12'h300, 8'h03);
    wr(12'h238, 8'h03);
    wr(12'h214, 8'h5A);
    wr(12'h204, 8'h3C);
    wr(12'h244, 8'h15);
    wr(12'h268, 8'hA5);
    wr(12'h26C, 8'h5A);
    rd(12'h238, 8'h03);
    // Wake in crystal mode settles without reset
    kick(5'h10, 1);
    #1;
    chk("wake hold", 32'h1, {31'h0, hold});
    chk("wake reset", 32'h0, {31'h0, core_rst});
    meas(1'b1);
    chk($sformatf("wake %0d", n), 32'h1, {31'h0, n >= 2 * S - 2 && n <= 2 * S + 2});
    chk("dir", 32'h5A, {24'h0, dir});
    mode <= RTS_RESISTOR_CAPACITOR_OSC;
    kick(5'h10, 1);
    #1;
    chk("rc wake", 32'h0, {31'h0, hold});
    kick(5'h04, 3);
    meas(1'b0);
    chk("dir", 32'hFF, {24'h0, dir});
    chk("opt", 32'hFF, {24'h0, opt});
    chk("trim", 32'h15, {26'h0, trim});
    chk("tmr3", 32'h5AA5, {16'h0, tmr3});
    rd(12'h238, 8'h03);
    kick(5'h08, 3);
    meas(1'b0);
    rd(12'h238, 8'h03);
    bcfg <= 2'h0;
    kick(5'h02, 3);
    rd(12'h238, 8'h03);
    bcfg <= 2'h1;
    kick(5'h02, 3);
    meas(1'b0);
    chk("trim", 32'h0, {26'h0, trim});
    chk("tmr3", 32'h5AA5, {16'h0, tmr3});
    rd(12'h238, 8'h02);
    chk("status", 32'h2, {30'h0, pwr});
    wr(12'h238, 8'h03);
    wr(12'h3FC, 8'hFF);
    rd(12'h3FC, 8'h00);
    // Pin held low past all time-outs
    dis_n <= 1'b0;
    @(posedge clk);
    src <= 5'h05;
    cy(3);
    src <= 5'h04;
    cy(40);
    chk("pin held", 32'h1, {31'h0, core_rst});
    src <= 5'h00;
    #1;
    chk("pin free", 32'h0, {31'h0, core_rst});
    rd(12'h238, 8'h01);
    tally_and_finish();
  end
endmodule
